// File: src/pg_alert_pkg.sv
// package: register map, field layout and flag types of the power-good / alert block
package pg_alert_pkg;
	localparam logic [7:0] SOURCE_ADDR = 8'h10; // status register index
	localparam logic [7:0] MASK_ADDR = 8'h11; // mask register index
	localparam logic [7:0] MASK_RESET = 8'h0f; // faults masked, power good unmasked
	localparam int GOOD_BIT = 4; // power good position
	localparam int OVERVOLTAGE_BIT = 3; // overvoltage position
	localparam int SHORT_BIT = 2; // hard short position
	localparam int THERM_BIT = 1; // thermal position
	localparam int OVERCURRENT_BIT = 0; // overcurrent position
	localparam int FLAG_W = 5; // implemented flag bits

	// raw events from the regulator core
	typedef struct packed {
		logic overvoltage_fault;
		logic short_fault;
		logic thermal_fault;
		logic overcurrent_fault;
	} fault_evt_type;

	// register access port of the serial interface
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;
endpackage : pg_alert_pkg

// File: src/pg_hysteresis.sv
// power-good comparator follower with hysteresis and ramp freeze
module pg_hysteresis (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic i_above_95, // output above 95 percent of target
	input wire logic i_below_85, // output below 85 percent of target
	input wire logic i_ramp, // soft start or voltage_ramp_event active
	output logic o_power_good_flag
);
	logic good_reg; // held flag
	logic good_next; // next flag

	// evaluate only while enabled and not ramping, otherwise hold
	assign good_next = (!i_enable || i_ramp) ? good_reg : // see RULE3
		i_below_85 ? 1'b0 : i_above_95 ? 1'b1 : good_reg; // see RULE1 see RULE2

	// flag register, cleared by reset
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			good_reg <= 1'b0;
		end else begin
			good_reg <= good_next;
		end
	end

	assign o_power_good_flag = good_reg;
endmodule : pg_hysteresis

// File: src/power_good_fault_irq.sv
// top: status and mask registers, sticky faults and open-drain alert pin
// What this block does
// RULE1: clear good under 85%, set over 95%
// RULE2: keep re-evaluating good while enabled
// RULE3: freeze good during soft start or ramp
// RULE4: set fault flag on each of four events
// RULE5: faults clear only on enable/supply cycle
// RULE6: alert pin open-drain NOR of masked flags
// RULE7: mask bit one removes flag from pin
// RULE8: pin low when any unmasked flag set
// RULE9: mask resets to 0x0f
// RULE10: host writes 0x10 for fault alerts
// RULE11: status register at 0x10, host readable
// RULE12: enable low resets fault, mask and good registers; o_rdata is reset only by supply
// RULE13: latch-off keeps interface and registers
// RULE14: good at bit 4, faults bits 3..0
// RULE15: faults captured whatever the mask
module power_good_fault_irq (
	input wire logic i_clk_sys,
	input wire logic i_rst_n, // supply power-on reset
	input wire logic i_enable, // enable pin
	input wire logic i_above_95,
	input wire logic i_below_85,
	input wire logic i_soft_start,
	input wire logic i_voltage_ramp_event,
	input wire pg_alert_pkg::fault_evt_type i_fault,
	input wire pg_alert_pkg::reg_req_type i_req,
	output logic [7:0] o_rdata, // read data, registered
	output logic o_good_or_alert_n_pin_out, // always 0 when driving
	output logic o_good_or_alert_n_pin_oe // high while pulling low
);
	logic reg_rst_n; // register reset: supply or enable low
	logic power_good_flag; // hysteresis output
	logic [3:0] fault_reg; // sticky faults
	logic [3:0] fault_next;
	logic [7:0] event_mask_reg;
	logic [7:0] event_mask_next;
	logic [7:0] event_source; // assembled status
	logic [7:0] rdata_next;
	logic alert_active; // any unmasked flag set
	logic mask_wr; // write hits mask

	// enable low returns fault, mask and good registers to default (o_rdata needs supply reset); latch-off is not a reset
	assign reg_rst_n = i_rst_n && i_enable; // see RULE12 see RULE13 see RULE5

	pg_hysteresis u_pg (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(reg_rst_n),
		.i_enable(i_enable),
		.i_above_95(i_above_95),
		.i_below_85(i_below_85),
		.i_ramp(i_soft_start || i_voltage_ramp_event),
		.o_power_good_flag(power_good_flag)
	);

	// sticky set independent of mask and of any access
	assign fault_next = fault_reg | {i_fault.overvoltage_fault, i_fault.short_fault,
		i_fault.thermal_fault, i_fault.overcurrent_fault}; // see RULE4 see RULE15

	// status layout
	assign event_source = {3'h0, power_good_flag, fault_reg}; // see RULE14 see RULE11

	// mask write decode
	assign mask_wr = i_req.wr && (i_req.addr == pg_alert_pkg::MASK_ADDR);
	assign event_mask_next = mask_wr ? {3'h0, i_req.wdata[pg_alert_pkg::FLAG_W-1:0]} : event_mask_reg; // see RULE7

	// read mux, unmapped reads as zero
	assign rdata_next = !i_req.rd ? o_rdata :
		(i_req.addr == pg_alert_pkg::SOURCE_ADDR) ? event_source : // see RULE11
		(i_req.addr == pg_alert_pkg::MASK_ADDR) ? event_mask_reg : 8'h00;

	// alert: NOR of unmasked flags drives pin low
	assign alert_active = |(event_source & ~event_mask_reg); // see RULE6 see RULE8 see RULE7
	assign o_good_or_alert_n_pin_out = 1'b0;
	assign o_good_or_alert_n_pin_oe = alert_active; // see RULE6

	// fault and mask registers
	always_ff @(posedge i_clk_sys) begin
		if (!reg_rst_n) begin
			fault_reg <= 4'h0;
			event_mask_reg <= pg_alert_pkg::MASK_RESET; // see RULE9
		end else begin
			fault_reg <= fault_next;
			event_mask_reg <= event_mask_next;
		end
	end

	// read data register kept across enable cycles only by supply reset
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= rdata_next;
		end
	end

	// pin follows flags and mask in the same cycle
	a_pin_follows_flags: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_good_or_alert_n_pin_oe == |(event_source & ~event_mask_reg)) // see RULE8
		else $error("alert pin disagrees with masked flags");
	a_fault_sticky: assert property (@(posedge i_clk_sys) disable iff (!reg_rst_n)
		i_fault.thermal_fault |=> fault_reg[1] [*3]) // see RULE5
		else $error("thermal flag not held");
	a_fault_sets: assert property (@(posedge i_clk_sys) disable iff (!reg_rst_n)
		i_fault.overvoltage_fault |=> event_source[pg_alert_pkg::OVERVOLTAGE_BIT]) // see RULE4
		else $error("overvoltage flag not set");
	a_mask_default: assert property (@(posedge i_clk_sys)
		$rose(reg_rst_n) |-> event_mask_reg == 8'h0f) // see RULE9
		else $error("mask not at default after reset");
	a_mask_write: assert property (@(posedge i_clk_sys) disable iff (!reg_rst_n)
		mask_wr ##1 reg_rst_n |-> event_mask_reg == {3'h0, $past(i_req.wdata[4:0])}) // see RULE7
		else $error("mask write lost");
	a_good_freeze: assert property (@(posedge i_clk_sys) disable iff (!reg_rst_n)
		(i_soft_start || i_voltage_ramp_event) |=> $stable(power_good_flag)) // see RULE3
		else $error("good changed during ramp");
	a_good_drop: assert property (@(posedge i_clk_sys) disable iff (!reg_rst_n)
		(i_enable && i_below_85 && !i_soft_start && !i_voltage_ramp_event) |=> !power_good_flag) // see RULE1
		else $error("good not cleared under 85 percent");
	a_source_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_req.rd && i_req.addr == 8'h10) |=> o_rdata == $past(event_source)) // see RULE11
		else $error("status read wrong");
	// an unmasked good flag must pull the pin whatever the faults do
	a_good_unmasked_pin: assert property (@(posedge i_clk_sys) disable iff (!reg_rst_n)
		(power_good_flag && !event_mask_reg[pg_alert_pkg::GOOD_BIT]) |-> o_good_or_alert_n_pin_oe) // see RULE8
		else $error("unmasked good flag does not pull pin");
	// unimplemented mask bits never hold a one
	a_mask_upper_zero: assert property (@(posedge i_clk_sys) disable iff (!reg_rst_n)
		event_mask_reg[7:5] == 3'h0) // see RULE7
		else $error("mask upper bits set");
	// read data stands until the next read strobe
	a_rdata_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_req.rd |=> $stable(o_rdata)) // see RULE11
		else $error("read data changed without read");
endmodule : power_good_fault_irq

// File: bench/alert_pullup.sv
// partner model: the system-side pull-up on the open-drain good/alert line
module alert_pullup (
	input wire logic i_out,
	input wire logic i_oe,
	output logic o_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// a released line is pulled high by the resistor
	assign o_pin = i_oe ? i_out : 1'b1;
endmodule : alert_pullup

// File: bench/power_good_fault_irq_test.sv
// testbench of the power-good and fault alert block
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin failures++; $display("BAD %0t %s", $time, m); end end
module power_good_fault_irq_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, a95 = 1'b0, b85 = 1'b1, ss = 1'b0, vr = 1'b0;
	pg_alert_pkg::fault_evt_type flt = '0; // fault events from the core
	pg_alert_pkg::reg_req_type req = '0; // register requests
	logic [7:0] rdata;
	logic pout, poe, pin;
	int failures = 0, comparisons = 0, cycles = 0;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	power_good_fault_irq dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_enable(en), .i_above_95(a95),
		.i_below_85(b85), .i_soft_start(ss), .i_voltage_ramp_event(vr), .i_fault(flt), .i_req(req),
		.o_rdata(rdata), .o_good_or_alert_n_pin_out(pout), .o_good_or_alert_n_pin_oe(poe));
	alert_pullup pull (.i_out(pout), .i_oe(poe), .o_pin(pin));
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			summarize();
		end
	end
	task summarize;
		if (failures == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	// one register access; reads are checked against exp
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge clk) req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk) req <= '0;
		#1 if (!w) `CHK(rdata, exp, "read data")
	endtask : acc
	// set comparators, freeze and let them settle
	task drive(input logic hi, input logic lo, input logic s, input logic r);
		@(posedge clk);
		a95 <= hi;
		b85 <= lo;
		ss <= s;
		vr <= r;
		repeat (3) @(posedge clk);
	endtask : drive
	task t_good;
		drive(1'b1, 1'b0, 1'b0, 1'b0);
		acc(1'b0, 8'h10, 8'h00, 8'h10);
		`CHK(pin, 1'b0, "good pin")
		drive(1'b0, 1'b1, 1'b1, 1'b0);
		acc(1'b0, 8'h10, 8'h00, 8'h10);
		drive(1'b0, 1'b1, 1'b0, 1'b0);
		acc(1'b0, 8'h10, 8'h00, 8'h00);
		`CHK(pin, 1'b1, "idle pin")
		drive(1'b1, 1'b0, 1'b0, 1'b1);
		acc(1'b0, 8'h10, 8'h00, 8'h00);
		drive(1'b0, 1'b1, 1'b0, 1'b0);
	endtask : t_good
	task t_fault;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) flt <= 4'(1 << i);
			@(posedge clk) flt <= '0;
			acc(1'b0, 8'h10, 8'h00, 8'((1 << (i + 1)) - 1));
			`CHK(pin, 1'b1, "masked pin")
		end
		acc(1'b1, 8'h10, 8'h00, 8'h00);
		acc(1'b0, 8'h10, 8'h00, 8'h0f);
		acc(1'b1, 8'h11, 8'hff, 8'h00);
		acc(1'b0, 8'h11, 8'h00, 8'h1f);
		acc(1'b1, 8'h11, 8'h10, 8'h00);
		`CHK(pin, 1'b0, "fault pin")
		acc(1'b0, 8'h20, 8'h00, 8'h00);
		@(posedge clk) en <= 1'b0;
		@(posedge clk) en <= 1'b1;
		acc(1'b0, 8'h10, 8'h00, 8'h00);
		acc(1'b0, 8'h11, 8'h00, 8'h0f);
	endtask : t_fault
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		en <= 1'b1;
		acc(1'b0, 8'h11, 8'h00, 8'h0f);
		`CHK(pin, 1'b1, "reset pin")
		t_good();
		t_fault();
		summarize();
	end
endmodule : power_good_fault_irq_test
